//--- smbus_word_slave_with_watchdog_tb.sv
// self-checking bench: host and device ends facing across the link
`timescale 1ns/100ps
`include "smw_map.svh"
module smbus_word_slave_with_watchdog_tb;
  localparam logic [15:0] PART = 16'hC3A7; // arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_i = 1'b0;
  logic        read_i = 1'b0;
  logic [7:0]  cmd_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        supply_ok_i = 1'b1;
  logic        adapter_detect_level_i = 1'b1;
  logic        wd_kick_i = 1'b0;
  logic        ready_o;
  logic        done_o;
  logic        nack_o;
  logic        timeout_o;
  logic [15:0] rdata_o;
  logic [15:0] charger_config_word_o;
  logic        cfg_wr_o;
  logic        busy_o;
  logic        wd_expired_o;
  logic [31:0] seed = 32'h0000001E;
  logic [17:0] host_q[$];
  logic [15:0] cfg_q[$];
  int          n_errors = 0;
  int          samples_checked = 0;

  smw_if link ();
  smw_host #(.TIMEOUT_CYC(2000)) u_smw_host (
    .clk_i, .rst_i, .bus(link.host), .req_i, .read_i, .cmd_i, .wdata_i,
    .ready_o, .done_o, .nack_o, .timeout_o, .rdata_o);
  smw_dev #(.TIMEOUT_CYC(2000), .MS_CYC(10), .DEGLITCH_CYC(20),
            .PART_ID(PART)) u_smw_dev (
    .clk_i, .rst_i, .bus(link.dev), .supply_ok_i, .adapter_detect_level_i,
    .wd_kick_i, .charger_config_word_o, .cfg_wr_o, .busy_o,
    .wd_expired_o);
  smw_link_assertions #(.TIMEOUT_CYC(2000)) u_smw_link_assertions (
    .clk_i, .rst_i, .host_scl_o(link.host_scl_o),
    .host_scl_oe_n(link.host_scl_oe_n), .host_sda_o(link.host_sda_o),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));

  initial forever #5 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic chk_host(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_host

  task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cfg

  task automatic chk_flags(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flags

  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      n_errors++;
      test_done();
    end
  endtask : bound

  // one word transfer: takes ~38k cycles to write, ~48k to read, hence only two per run
  task automatic xfer(input logic rd, input logic [7:0] cmd,
                      input logic [15:0] wd);
    int i;
    for (i = 0; i < 100 && ready_o !== 1'b1; i++)
      @(negedge clk_i);
    bound(i, 100);
    read_i = rd;
    cmd_i = cmd;
    wdata_i = wd;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    for (i = 0; i < 80000 && done_o !== 1'b1; i++)
      @(negedge clk_i);
    bound(i, 80000);
    @(negedge clk_i);
  endtask : xfer

  // ------------------------------------------------------------
  // result watchers
  // ------------------------------------------------------------
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      chk_host({timeout_o, nack_o, rdata_o}, host_q.pop_front());
      // stop frees the device well before the host ends its stop phase
      chk_flags({busy_o, wd_expired_o}, 2'b00);
    end
    if (cfg_wr_o === 1'b1)
      chk_cfg(charger_config_word_o, cfg_q.pop_front());
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk_cfg(charger_config_word_o, `SMW_CFG_RST);
    repeat (10) @(negedge clk_i);
    wd_kick_i = 1'b1;
    seed = xs(seed);
    cfg_q.push_back(seed[15:0]);
    host_q.push_back(18'h00000);
    xfer(1'b0, `SMW_CMD_CFG, seed[15:0]);
    wd_kick_i = 1'b0;
    host_q.push_back({2'b00, PART});
    xfer(1'b1, `SMW_CMD_PART, 16'h0000);
    test_done();
  end
endmodule : smbus_word_slave_with_watchdog_tb

//--- smw_dev.sv
// smbus word slave end: config word, id words, host watchdog
`timescale 1ns/100ps
`include "smw_map.svh"
module smw_dev #(
  parameter int          TIMEOUT_CYC  = `SMW_TIMEOUT_CYC,
  parameter int          MS_CYC       = `SMW_CYC_PER_MS,
  parameter int          DEGLITCH_CYC = `SMW_DEGLITCH_CYC,
  parameter logic [15:0] PART_ID      = 16'h5A01, // arbitrary value
  parameter logic [15:0] MAKER_ID     = 16'h00A5  // arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  smw_if.dev               bus,
  input  wire logic        supply_ok_i,
  input  wire logic        adapter_detect_level_i,
  input  wire logic        wd_kick_i,
  output logic      [15:0] charger_config_word_o,
  output logic             cfg_wr_o,
  output logic             busy_o,
  output logic             wd_expired_o
);
  // ------------------------------------------------------------
  // pin sampling and bus conditions
  // ------------------------------------------------------------
  logic [4:0]                s_w;
  logic                      scl_s;
  logic                      sda_s;
  logic                      link_en;
  logic                      kick_s;
  logic                      scl_prev_reg;
  logic                      sda_prev_reg;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;

  smw_sync #(.W(5), .RST(5'h03)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({wd_kick_i, adapter_detect_level_i, supply_ok_i,
             bus.sda, bus.scl}),
    .q_o   (s_w)
  );

  assign scl_s   = s_w[0];
  assign sda_s   = s_w[1];
  assign link_en = s_w[2] & s_w[3];
  assign kick_s  = s_w[4];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign scl_fall  = ~scl_s & scl_prev_reg;
  // data may only move with scl low, so these are unambiguous
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ------------------------------------------------------------
  // transaction state
  // ------------------------------------------------------------
  smw_pkg::dev_state_type    state_reg;
  smw_pkg::dev_state_type    nxt_reg;
  smw_pkg::dev_state_type    nxt_next;
  logic [3:0]                cnt_reg;
  logic [7:0]                shift_reg;
  logic [7:0]                cmd_reg;
  logic [7:0]                lo_reg;
  logic [7:0]                tx_reg;
  logic                      drv_low_reg;
  logic                      ack_next;
  logic                      known_cmd;
  logic [15:0]               rd_word;
  logic                      wr_commit;
  logic                      tmo_hit;
  logic                      rx_state;
  logic [15:0]               cfg_reg;

  assign known_cmd = (cmd_reg == `SMW_CMD_CFG) ||
                     (cmd_reg == `SMW_CMD_MAKER) ||
                     (cmd_reg == `SMW_CMD_PART);

  always_comb begin
    if (cmd_reg == `SMW_CMD_PART) begin
      rd_word = PART_ID;
    end else if (cmd_reg == `SMW_CMD_MAKER) begin
      rd_word = MAKER_ID;
    end else begin
      rd_word = cfg_reg;
    end
  end

  assign rx_state = (state_reg == smw_pkg::DEV_ADDR) ||
                    (state_reg == smw_pkg::DEV_CMD) ||
                    (state_reg == smw_pkg::DEV_WR_LO) ||
                    (state_reg == smw_pkg::DEV_WR_HI);

  // acknowledge and successor for the byte just received
  always_comb begin
    ack_next = 1'b0;
    nxt_next = smw_pkg::DEV_IGNORE;
    case (state_reg)
      smw_pkg::DEV_ADDR: begin
        if (shift_reg[7:1] == 7'(`SMW_ADDR_BYTE >> 1)) begin
          if (!shift_reg[0]) begin
            ack_next = 1'b1;
            nxt_next = smw_pkg::DEV_CMD;
          end else if (known_cmd) begin
            ack_next = 1'b1;
            nxt_next = smw_pkg::DEV_RD_LO;
          end
        end
      end
      smw_pkg::DEV_CMD: begin
        if ((shift_reg == `SMW_CMD_CFG) ||
            (shift_reg == `SMW_CMD_MAKER) ||
            (shift_reg == `SMW_CMD_PART)) begin
          ack_next = 1'b1;
          nxt_next = smw_pkg::DEV_WR_LO;
        end
      end
      smw_pkg::DEV_WR_LO: begin
        // id words are read-only, so their data is refused
        if (cmd_reg == `SMW_CMD_CFG) begin
          ack_next = 1'b1;
          nxt_next = smw_pkg::DEV_WR_HI;
        end
      end
      smw_pkg::DEV_WR_HI: begin
        ack_next = 1'b1;
      end
      smw_pkg::DEV_RD_LO: begin
        nxt_next = smw_pkg::DEV_RD_HI;
      end
      default: begin
        nxt_next = smw_pkg::DEV_IGNORE;
      end
    endcase
  end

  assign wr_commit = scl_fall && (cnt_reg == 4'h8) &&
                     (state_reg == smw_pkg::DEV_WR_HI);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= smw_pkg::DEV_IDLE;
      nxt_reg     <= smw_pkg::DEV_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      lo_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      drv_low_reg <= 1'b0;
    end else if (!link_en || tmo_hit) begin
      state_reg   <= smw_pkg::DEV_IDLE;
      drv_low_reg <= 1'b0;
      cnt_reg     <= 4'h0;
    end else if (start_det) begin
      state_reg   <= smw_pkg::DEV_ADDR;
      cnt_reg     <= 4'h0;
      drv_low_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg   <= smw_pkg::DEV_IDLE;
      drv_low_reg <= 1'b0;
    end else if (scl_rise) begin
      if (cnt_reg < 4'h8) begin
        shift_reg <= {shift_reg[6:0], sda_s};
      end else if (cnt_reg == 4'h8 && !rx_state && sda_s) begin
        state_reg <= smw_pkg::DEV_IGNORE; // master nack ends read
      end
      if (cnt_reg < 4'h9) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end else if (scl_fall && state_reg != smw_pkg::DEV_IDLE &&
                 state_reg != smw_pkg::DEV_IGNORE) begin
      // all drive changes happen just after scl falls
      if (cnt_reg == 4'h8) begin
        nxt_reg     <= nxt_next;
        drv_low_reg <= rx_state & ack_next;
        if (state_reg == smw_pkg::DEV_CMD) begin
          cmd_reg <= shift_reg;
        end
        if (state_reg == smw_pkg::DEV_WR_LO) begin
          lo_reg <= shift_reg;
        end
      end else if (cnt_reg == 4'h9) begin
        cnt_reg   <= 4'h0;
        state_reg <= nxt_reg;
        if (nxt_reg == smw_pkg::DEV_RD_LO) begin
          tx_reg      <= {rd_word[6:0], 1'b0};
          drv_low_reg <= ~rd_word[7];
        end else if (nxt_reg == smw_pkg::DEV_RD_HI) begin
          tx_reg      <= {rd_word[14:8], 1'b0};
          drv_low_reg <= ~rd_word[15];
        end else begin
          drv_low_reg <= 1'b0;
        end
      end else if (!rx_state) begin
        drv_low_reg <= ~tx_reg[7];
        tx_reg      <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // clock-low timeout
  // ------------------------------------------------------------
  logic [31:0]               tmo_cnt_reg;

  // never stretches scl itself, so only master low time counts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmo_cnt_reg <= 32'h0;
    end else if (state_reg == smw_pkg::DEV_IDLE || scl_s) begin
      tmo_cnt_reg <= 32'h0;
    end else if (!tmo_hit) begin
      tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
    end
  end

  assign tmo_hit = (tmo_cnt_reg == 32'(TIMEOUT_CYC - 1));

  // ------------------------------------------------------------
  // configuration word
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg  <= `SMW_CFG_RST;
      cfg_wr_o <= 1'b0;
    end else begin
      cfg_wr_o <= wr_commit;
      if (wr_commit) begin
        cfg_reg <= {shift_reg, lo_reg};
      end
    end
  end

  assign charger_config_word_o = cfg_reg;
  assign busy_o                = (state_reg != smw_pkg::DEV_IDLE);
  assign bus.dev_sda_o         = 1'b0;
  assign bus.dev_sda_oe_n      = ~drv_low_reg;

  // ------------------------------------------------------------
  // host watchdog
  // ------------------------------------------------------------
  logic [31:0]               kick_cnt_reg;
  logic                      restart;
  logic [31:0]               ms_cnt_reg;
  logic [31:0]               wd_ms_reg;
  logic [31:0]               period_ms;
  logic                      expire;
  logic                      wd_exp_reg;

  // kick must stay high for the full deglitch span
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      kick_cnt_reg <= 32'h0;
    end else if (!kick_s) begin
      kick_cnt_reg <= 32'h0;
    end else if (kick_cnt_reg != 32'(DEGLITCH_CYC)) begin
      kick_cnt_reg <= kick_cnt_reg + 32'h1;
    end
  end

  assign restart = (kick_cnt_reg == 32'(DEGLITCH_CYC - 1));

  always_comb begin
    case (cfg_reg[`SMW_WD_MSB:`SMW_WD_LSB])
      2'h1:    period_ms = 32'(`SMW_WD01_MS);
      2'h2:    period_ms = 32'(`SMW_WD10_MS);
      2'h3:    period_ms = 32'(`SMW_WD11_MS);
      default: period_ms = 32'h0;
    endcase
  end

  assign expire = (period_ms != 32'h0) && (wd_ms_reg >= period_ms);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_reg <= 32'h0;
      wd_ms_reg  <= 32'h0;
    end else if (restart || period_ms == 32'h0) begin
      ms_cnt_reg <= 32'h0;
      wd_ms_reg  <= 32'h0;
    end else if (ms_cnt_reg == 32'(MS_CYC - 1)) begin
      ms_cnt_reg <= 32'h0;
      if (!expire) begin
        wd_ms_reg <= wd_ms_reg + 32'h1;
      end
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end

  // expiry in the same cycle as a restart still wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_exp_reg <= 1'b0;
    end else if (expire) begin
      wd_exp_reg <= 1'b1;
    end else if (restart) begin
      wd_exp_reg <= 1'b0;
    end
  end

  assign wd_expired_o = wd_exp_reg;
endmodule : smw_dev

//--- smw_host.sv
// smbus word master end driving read-word and write-word
`timescale 1ns/100ps
`include "smw_map.svh"
module smw_host #(
  parameter int TIMEOUT_CYC = `SMW_TIMEOUT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  smw_if.host              bus,
  input  wire logic        req_i,
  input  wire logic        read_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [15:0] wdata_i,
  output logic             ready_o,
  output logic             done_o,
  output logic             nack_o,
  output logic             timeout_o,
  output logic      [15:0] rdata_o
);
  logic [1:0]                s_w;
  smw_pkg::hst_state_type    st_reg;
  logic [1:0]                q_reg;
  logic [15:0]               div_reg;
  logic [2:0]                pos_reg;
  logic [3:0]                bit_reg;
  logic [7:0]                rx_reg;
  logic [7:0]                lo_reg;
  logic [7:0]                cmd_reg;
  logic [15:0]               wd_reg;
  logic                      read_reg;
  logic                      nak_reg;
  logic                      scl_low_reg;
  logic                      sda_low_reg;
  logic [31:0]               low_cnt_reg;
  logic                      tick;
  logic                      adv;
  logic                      abort;
  logic                      mrx;
  logic [7:0]                tx_byte;

  smw_sync #(.W(2), .RST(2'h3)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bus.sda, bus.scl}),
    .q_o   (s_w)
  );

  assign tick = (div_reg == 16'(`SMW_QTR_CYC - 1));
  // the high phase waits while a slave holds scl low
  assign adv  = tick && (q_reg != 2'h2 || s_w[0]);
  assign mrx  = read_reg && (pos_reg >= 3'h3);

  always_comb begin
    case (pos_reg)
      3'h0:    tx_byte = `SMW_ADDR_BYTE;
      3'h1:    tx_byte = cmd_reg;
      3'h2:    tx_byte = read_reg ? (`SMW_ADDR_BYTE | 8'h01) : wd_reg[7:0];
      default: tx_byte = wd_reg[15:8];
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg     <= 16'h0;
      low_cnt_reg <= 32'h0;
    end else begin
      div_reg <= (st_reg == smw_pkg::HST_IDLE || tick) ? 16'h0
                                                       : div_reg + 16'h1;
      if (st_reg == smw_pkg::HST_IDLE || s_w[0]) begin
        low_cnt_reg <= 32'h0;
      end else begin
        low_cnt_reg <= low_cnt_reg + 32'h1;
      end
    end
  end

  assign abort = (low_cnt_reg == 32'(TIMEOUT_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg      <= smw_pkg::HST_IDLE;
      q_reg       <= 2'h0;
      pos_reg     <= 3'h0;
      bit_reg     <= 4'h0;
      rx_reg      <= 8'h00;
      lo_reg      <= 8'h00;
      cmd_reg     <= 8'h00;
      wd_reg      <= 16'h0;
      read_reg    <= 1'b0;
      nak_reg     <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      done_o      <= 1'b0;
      nack_o      <= 1'b0;
      timeout_o   <= 1'b0;
      rdata_o     <= 16'h0;
    end else begin
      done_o <= 1'b0;
      if (abort) begin
        st_reg      <= smw_pkg::HST_IDLE;
        scl_low_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        timeout_o   <= 1'b1;
        done_o      <= 1'b1;
      end else if (st_reg == smw_pkg::HST_IDLE) begin
        if (req_i) begin
          st_reg    <= smw_pkg::HST_START;
          q_reg     <= 2'h0;
          pos_reg   <= 3'h0;
          bit_reg   <= 4'h0;
          nak_reg   <= 1'b0;
          nack_o    <= 1'b0;
          timeout_o <= 1'b0;
          cmd_reg   <= cmd_i;
          wd_reg    <= wdata_i;
          read_reg  <= read_i;
        end
      end else if (adv) begin
        q_reg <= q_reg + 2'h1;
        case (st_reg)
          smw_pkg::HST_START: begin
            case (q_reg)
              2'h0: sda_low_reg <= 1'b0;
              2'h1: scl_low_reg <= 1'b0;
              2'h2: sda_low_reg <= 1'b1;
              default: begin
                scl_low_reg <= 1'b1;
                st_reg      <= smw_pkg::HST_BIT;
              end
            endcase
          end
          smw_pkg::HST_BIT: begin
            case (q_reg)
              2'h0: begin
                if (bit_reg < 4'h8) begin
                  sda_low_reg <= ~mrx & ~tx_byte[3'(4'h7 - bit_reg)];
                end else begin
                  sda_low_reg <= mrx & (pos_reg == 3'h3);
                end
              end
              2'h1: scl_low_reg <= 1'b0;
              2'h2: begin
                if (bit_reg < 4'h8) begin
                  rx_reg <= {rx_reg[6:0], s_w[1]};
                end else if (!mrx && s_w[1]) begin
                  nak_reg <= 1'b1;
                  nack_o  <= 1'b1;
                end
              end
              default: begin
                scl_low_reg <= 1'b1;
                if (bit_reg < 4'h8) begin
                  bit_reg <= bit_reg + 4'h1;
                end else begin
                  bit_reg <= 4'h0;
                  pos_reg <= pos_reg + 3'h1;
                  if (pos_reg == 3'h3) begin
                    lo_reg <= rx_reg;
                  end
                  if (pos_reg == 3'h4) begin
                    rdata_o <= {rx_reg, lo_reg};
                  end
                  if (nak_reg || pos_reg >= 3'h3 &&
                      (!read_reg || pos_reg == 3'h4)) begin
                    st_reg <= smw_pkg::HST_STOP;
                  end else if (read_reg && pos_reg == 3'h1) begin
                    st_reg <= smw_pkg::HST_START;
                  end
                end
              end
            endcase
          end
          default: begin
            case (q_reg)
              2'h0: sda_low_reg <= 1'b1;
              2'h1: scl_low_reg <= 1'b0;
              2'h2: sda_low_reg <= 1'b0;
              default: begin
                st_reg <= smw_pkg::HST_IDLE;
                done_o <= 1'b1;
              end
            endcase
          end
        endcase
      end
    end
  end

  assign ready_o           = (st_reg == smw_pkg::HST_IDLE);
  assign bus.host_scl_o    = 1'b0;
  assign bus.host_scl_oe_n = ~scl_low_reg;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = ~sda_low_reg;
endmodule : smw_host

//--- smw_if.sv
// open-drain smbus wires joining host and device ends
`timescale 1ns/100ps
interface smw_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // pull-ups win unless a party enables a low drive
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n,
    input  scl,
    input  sda
  );

  modport dev (
    output dev_sda_o,
    output dev_sda_oe_n,
    input  scl,
    input  sda
  );
endinterface : smw_if

//--- smw_link_assertions.sv
// concurrent checks on the wires of the smbus word link
`timescale 1ns/100ps
module smw_link_assertions #(
  parameter int TIMEOUT_CYC = 2000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       first_reg;
  logic [3:0] nbit_reg;
  logic [7:0] shf_reg;
  int         low_reg;
  logic       ack_due;

  // ------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // a repeated start re-arms the address byte, so reads are seen too
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_reg <= 1'b0;
      nbit_reg  <= 4'h0;
      shf_reg   <= 8'h00;
    end else if (scl && scl_q && sda_q && !sda) begin
      first_reg <= 1'b1;
      nbit_reg  <= 4'h0;
    end else if (scl && !scl_q) begin
      nbit_reg <= (nbit_reg == 4'h8) ? 4'h0 : nbit_reg + 4'h1;
      shf_reg  <= {shf_reg[6:0], sda};
      if (nbit_reg == 4'h8)
        first_reg <= 1'b0;
    end
  end

  // idle line sits high, so only low time inside a frame accrues
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      low_reg <= 0;
    else
      low_reg <= scl ? 0 : low_reg + 1;
  end

  assign ack_due = first_reg && (nbit_reg == 4'h8) && scl && !scl_q
                   && (shf_reg[7:1] == 7'h09);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence

  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_open_drain: assert property (
    !host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("open-drain line driven high");
  a_no_dev_start: assert property (
    start_s |-> !host_sda_oe_n) else $error("start not made by host");
  a_dev_edge_low: assert property (
    $changed(dev_sda_oe_n) |-> !scl) else $error("device sda moved, scl high");
  a_stop_frees: assert property (
    stop_s |-> dev_sda_oe_n [*8]) else $error("device holds sda after stop");
  a_addr_ack: assert property (
    ack_due |-> !dev_sda_oe_n) else $error("own address not acknowledged");
  a_scl_high_min: assert property (
    $rose(scl) |-> scl [*8]) else $error("scl high pulse too short");
  a_data_stable: assert property (
    $rose(scl) |=> $stable(sda) [*8]) else $error("sda moved after scl rise");
  a_scl_low_bound: assert property (
    low_reg < TIMEOUT_CYC) else $error("scl held low too long");
endmodule : smw_link_assertions

//--- smw_map.svh
// constants for the smbus word slave and its host end
`ifndef SMW_MAP_SVH
`define SMW_MAP_SVH

// ------------------------------------------------------------
// addresses and commands
// ------------------------------------------------------------
`define SMW_ADDR_BYTE   8'h12
`define SMW_CMD_CFG     8'h12
`define SMW_CMD_MAKER   8'hFE
`define SMW_CMD_PART    8'hFF
`define SMW_CFG_RST     16'h6000
`define SMW_WD_LSB      13
`define SMW_WD_MSB      14

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SMW_CLK_KHZ       100000
`define SMW_CYC_PER_MS    (`SMW_CLK_KHZ)
`define SMW_T_TIMEOUT_MS  25
`define SMW_TIMEOUT_CYC   (`SMW_T_TIMEOUT_MS * `SMW_CYC_PER_MS)
`define SMW_T_DEGLITCH_MS 10
`define SMW_DEGLITCH_CYC  (`SMW_T_DEGLITCH_MS * `SMW_CYC_PER_MS)
`define SMW_T_WD01_S      44
`define SMW_T_WD10_S      88
`define SMW_T_WD11_S      175
`define SMW_WD01_MS       (`SMW_T_WD01_S * 1000)
`define SMW_WD10_MS       (`SMW_T_WD10_S * 1000)
`define SMW_WD11_MS       (`SMW_T_WD11_S * 1000)
`define SMW_SCL_KHZ       100
`define SMW_QTR_CYC       (`SMW_CLK_KHZ / (`SMW_SCL_KHZ * 4))

`endif

//--- smw_pkg.sv
// types shared by both ends of the smbus word link
package smw_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_ADDR,
    DEV_CMD,
    DEV_WR_LO,
    DEV_WR_HI,
    DEV_RD_LO,
    DEV_RD_HI,
    DEV_IGNORE
  } dev_state_type;

  typedef enum logic [1:0] {
    HST_IDLE,
    HST_START,
    HST_BIT,
    HST_STOP
  } hst_state_type;

endpackage : smw_pkg

//--- smw_sync.sv
// three-flop pin synchroniser, output moves when last two agree
`timescale 1ns/100ps
module smw_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_reg <= RST[i];
          s2_reg <= RST[i];
          s3_reg <= RST[i];
          q_reg  <= RST[i];
        end else begin
          s1_reg <= d_i[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign q_o[i] = q_reg;
    end
  endgenerate
endmodule : smw_sync
